//--- hdl/s2l4_pkg.sv
// Constants and carrier types for the stage-2 level-4 entry decoder.
// Assumes a 64-bit paging entry and a 32-bit register port.
package s2l4_pkg;

    localparam int ENTRY_W = 64;
    localparam int DATA_W = 32;
    localparam int REG_AW = 5;
    localparam int HAW_DEFAULT = 48;
    localparam int CNT_W = 32;

    // Entry field positions
    localparam int POS_IGN_TOP = 63;
    localparam int POS_IO_WR = 62;
    localparam int POS_IO_RD = 61;
    localparam int POS_RSVD_HI = 51;
    localparam int POS_BASE_LO = 12;
    localparam int POS_RSVD_11 = 11;
    localparam int POS_ACC = 8;
    localparam int POS_RSVD_7 = 7;
    localparam int POS_WR = 1;
    localparam int POS_RD = 0;

    // Register offsets
    localparam logic [REG_AW-1:0] OFS_CTRL = 5'h00;
    localparam logic [REG_AW-1:0] OFS_STATUS = 5'h04;
    localparam logic [REG_AW-1:0] OFS_BASE_LO = 5'h08;
    localparam logic [REG_AW-1:0] OFS_BASE_HI = 5'h0C;
    localparam logic [REG_AW-1:0] OFS_ENTRY_LO = 5'h10;
    localparam logic [REG_AW-1:0] OFS_ENTRY_HI = 5'h14;
    localparam logic [REG_AW-1:0] OFS_CNT_DECODE = 5'h18;
    localparam logic [REG_AW-1:0] OFS_CNT_DENY = 5'h1C;

    localparam int CTRL_W = 3;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h0;
    localparam int STATUS_W = 5;

    typedef struct packed {
        logic dirty_enable;   // second_stage_dirty_enable
        logic zlr_support;    // zero_length_read_support
        logic io_mode;        // I/O permission mode
    } ctrl_t;

    typedef struct packed {
        logic [ENTRY_W-1:0] entry;
        logic is_read;
        logic is_write;
        logic zero_len;
    } walk_req_t;

    typedef struct packed {
        logic [ENTRY_W-1:0] next_base;
        logic rsvd_fault;
        logic read_ok;
        logic write_ok;
        logic granted;
    } result_t;

    typedef struct packed {
        ctrl_t ctrl;
        result_t res;
        logic res_valid;
        logic seen;
        logic acc_upd;
        logic [ENTRY_W-1:0] acc_entry;
        logic [ENTRY_W-1:0] last_entry;
        logic [CNT_W-1:0] cnt_decode;
        logic [CNT_W-1:0] cnt_deny;
        logic [DATA_W-1:0] rdata;
    } state_t;

endpackage

//--- hdl/s2l4_perm_check.sv
// Read and write permission of one level-4 entry for one request.
// Purely combinational; the caller registers the outcome.
`timescale 1ns/1ns
module s2l4_perm_check (
    input wire s2l4_pkg::ctrl_t ctrl,
    input wire logic [s2l4_pkg::ENTRY_W-1:0] entry,
    input wire logic zero_len,
    output logic read_ok,
    output logic write_ok
);
    logic wr_bit;
    logic rd_bit;

    always_comb begin
        if (ctrl.io_mode) begin
            wr_bit = entry[s2l4_pkg::POS_IO_WR];
            rd_bit = entry[s2l4_pkg::POS_IO_RD];
        end else begin
            wr_bit = entry[s2l4_pkg::POS_WR];
            rd_bit = entry[s2l4_pkg::POS_RD];
        end
        write_ok = wr_bit;
        // Zero-length reads ride on write permission when supported
        read_ok = rd_bit | (ctrl.zlr_support & zero_len & wr_bit);
    end

endmodule // s2l4_perm_check

//--- hdl/s2l4_rsvd_check.sv
// Reserved-bit check and next-table base extraction for a level-4 entry.
// Assumes 12 < HOST_ADDRESS_WIDTH <= 52.
`timescale 1ns/1ns
module s2l4_rsvd_check #(
    parameter int HOST_ADDRESS_WIDTH = s2l4_pkg::HAW_DEFAULT
) (
    input wire logic [s2l4_pkg::ENTRY_W-1:0] entry,
    input wire logic io_mode,
    output logic fault,
    output logic [s2l4_pkg::ENTRY_W-1:0] base
);
    logic [s2l4_pkg::ENTRY_W-1:0] mask;

    always_comb begin
        mask = '0;
        for (int i = HOST_ADDRESS_WIDTH; i <= s2l4_pkg::POS_RSVD_HI; i++) begin
            mask[i] = 1'b1;
        end
        mask[s2l4_pkg::POS_RSVD_11] = 1'b1;
        mask[s2l4_pkg::POS_RSVD_7] = 1'b1;
        mask[s2l4_pkg::POS_IO_WR] = ~io_mode;
        fault = |(entry & mask);
        base = '0;
        for (int i = s2l4_pkg::POS_BASE_LO; i < HOST_ADDRESS_WIDTH; i++) begin
            base[i] = entry[i];
        end
    end

endmodule // s2l4_rsvd_check

//--- hdl/s2l4_entry_decode.sv
// Stage-2 level-4 entry decoder: checks one walker-fetched entry,
// grants or denies the request, yields the next table base and
// asks for the accessed bit to be set.
// Assumes the walker and the register master share CLK_SYS.
// Function
// - With I/O mode off, io_write_permit bit 62 is reserved, must be zero.
// - With I/O mode on, io_write_permit zero denies writes to region.
// - With I/O mode on, io_read_permit zero denies reads; else ignored.
// - I/O mode, zero-length support: zero-length skips read check if write set.
// - With I/O mode off, write_permit bit 1 zero denies writes.
// - With I/O mode off, read_permit bit 0 zero denies reads.
// - Legacy mode, zero-length support: zero-length read skips check if write set.
// - Bits host_address_width-1 down to 12 give next table base.
// - Accessed flag bit 8 records use in a completed translation.
// - Dirty enable zero: accessed flag neither interpreted nor updated.
`timescale 1ns/1ns
module s2l4_entry_decode #(
    parameter int HOST_ADDRESS_WIDTH = s2l4_pkg::HAW_DEFAULT
) (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic WALK_VALID,
    input wire s2l4_pkg::walk_req_t WALK_REQ,
    output logic RES_VALID,
    output s2l4_pkg::result_t RES,
    output logic ACC_UPD,
    output logic [s2l4_pkg::ENTRY_W-1:0] ACC_ENTRY,
    input wire logic [s2l4_pkg::REG_AW-1:0] REG_ADDR,
    input wire logic [s2l4_pkg::DATA_W-1:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [s2l4_pkg::DATA_W-1:0] REG_RDATA
);
    s2l4_pkg::state_t state_ff;
    s2l4_pkg::state_t nxt_state;

    logic perm_rd_ok;
    logic perm_wr_ok;
    logic rsvd_fault;
    logic [s2l4_pkg::ENTRY_W-1:0] next_base;
    logic granted;
    logic acc_clear;

    // Counter step; a clear in the same cycle as an event keeps the event
    function automatic logic [s2l4_pkg::CNT_W-1:0] count_step(
        input logic [s2l4_pkg::CNT_W-1:0] cur,
        input logic clr,
        input logic inc
    );
        logic [s2l4_pkg::CNT_W-1:0] base;
        base = clr ? '0 : cur;
        count_step = base + {{(s2l4_pkg::CNT_W-1){1'b0}}, inc};
    endfunction

    // Low or high half of a 64-bit value as a register word
    function automatic logic [s2l4_pkg::DATA_W-1:0] half_word(
        input logic [s2l4_pkg::ENTRY_W-1:0] val,
        input logic hi
    );
        half_word = hi ? val[s2l4_pkg::ENTRY_W-1:s2l4_pkg::DATA_W]
                       : val[s2l4_pkg::DATA_W-1:0];
    endfunction

    function automatic logic [s2l4_pkg::DATA_W-1:0] read_mux(
        input s2l4_pkg::state_t s,
        input logic [s2l4_pkg::REG_AW-1:0] addr
    );
        logic [s2l4_pkg::STATUS_W-1:0] status;
        status = {s.res.granted, s.res.rsvd_fault, s.res.write_ok,
                  s.res.read_ok, s.seen};
        read_mux = '0;
        unique case (addr)
            s2l4_pkg::OFS_CTRL: begin
                read_mux[s2l4_pkg::CTRL_W-1:0] = s.ctrl;
            end
            s2l4_pkg::OFS_STATUS: begin
                read_mux[s2l4_pkg::STATUS_W-1:0] = status;
            end
            s2l4_pkg::OFS_BASE_LO: begin
                read_mux = half_word(s.res.next_base, 1'b0);
            end
            s2l4_pkg::OFS_BASE_HI: begin
                read_mux = half_word(s.res.next_base, 1'b1);
            end
            s2l4_pkg::OFS_ENTRY_LO: begin
                read_mux = half_word(s.last_entry, 1'b0);
            end
            s2l4_pkg::OFS_ENTRY_HI: begin
                read_mux = half_word(s.last_entry, 1'b1);
            end
            s2l4_pkg::OFS_CNT_DECODE: begin
                read_mux = s.cnt_decode;
            end
            s2l4_pkg::OFS_CNT_DENY: begin
                read_mux = s.cnt_deny;
            end
            default: begin
                read_mux = '0;
            end
        endcase
    endfunction

    // Mode bits come from the live control register, so a change
    // takes effect on the next entry presented
    s2l4_perm_check u_perm (
        .ctrl(state_ff.ctrl),
        .entry(WALK_REQ.entry),
        .zero_len(WALK_REQ.zero_len),
        .read_ok(perm_rd_ok),
        .write_ok(perm_wr_ok)
    );

    s2l4_rsvd_check #(
        .HOST_ADDRESS_WIDTH(HOST_ADDRESS_WIDTH)
    ) u_rsvd (
        .entry(WALK_REQ.entry),
        .io_mode(state_ff.ctrl.io_mode),
        .fault(rsvd_fault),
        .base(next_base)
    );

    // A reserved-bit fault denies everything; ignored bits never reach
    // any decision
    assign granted = ~rsvd_fault
                     & (~WALK_REQ.is_read | perm_rd_ok)
                     & (~WALK_REQ.is_write | perm_wr_ok);

    // Accessed bit only counts when dirty tracking is on
    assign acc_clear = state_ff.ctrl.dirty_enable
                       & ~WALK_REQ.entry[s2l4_pkg::POS_ACC];

    always_comb begin
        nxt_state = state_ff;
        nxt_state.res_valid = 1'b0;
        nxt_state.acc_upd = 1'b0;
        nxt_state.rdata = '0;

        if (REG_WR && REG_ADDR == s2l4_pkg::OFS_CTRL) begin
            nxt_state.ctrl = REG_WDATA[s2l4_pkg::CTRL_W-1:0];
        end

        nxt_state.cnt_decode = count_step(state_ff.cnt_decode,
            REG_WR && REG_ADDR == s2l4_pkg::OFS_CNT_DECODE, WALK_VALID);
        nxt_state.cnt_deny = count_step(state_ff.cnt_deny,
            REG_WR && REG_ADDR == s2l4_pkg::OFS_CNT_DENY,
            WALK_VALID & ~granted);

        if (WALK_VALID) begin
            nxt_state.res_valid = 1'b1;
            nxt_state.seen = 1'b1;
            nxt_state.last_entry = WALK_REQ.entry;
            nxt_state.res.rsvd_fault = rsvd_fault;
            nxt_state.res.read_ok = perm_rd_ok & ~rsvd_fault;
            nxt_state.res.write_ok = perm_wr_ok & ~rsvd_fault;
            nxt_state.res.granted = granted;
            nxt_state.res.next_base = next_base;
            // Translation completes on grant; mark the entry used
            if (granted && acc_clear) begin
                nxt_state.acc_upd = 1'b1;
                nxt_state.acc_entry = WALK_REQ.entry
                    | ({{(s2l4_pkg::ENTRY_W-1){1'b0}}, 1'b1}
                       << s2l4_pkg::POS_ACC);
            end
        end

        // Read data stand only in the cycle after the strobe
        if (REG_RD) begin
            nxt_state.rdata = read_mux(state_ff, REG_ADDR);
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            state_ff <= '0;
            state_ff.ctrl <= s2l4_pkg::CTRL_RESET;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign RES_VALID = state_ff.res_valid;
    assign RES = state_ff.res;
    assign ACC_UPD = state_ff.acc_upd;
    assign ACC_ENTRY = state_ff.acc_entry;
    assign REG_RDATA = state_ff.rdata;

endmodule // s2l4_entry_decode

//--- bench/s2l4_table_model.sv
// Table model: one host-memory entry slot feeding the walk port.
// Assumes the bench loads and fetches right after clock edges.
`timescale 1ns/1ns
module s2l4_table_model (
    input wire logic clk,
    input wire logic ld,
    input wire logic [63:0] ld_data,
    input wire logic fetch,
    input wire logic [2:0] flags,
    input wire logic acc_upd,
    input wire logic [63:0] acc_entry,
    output logic walk_valid,
    output s2l4_pkg::walk_req_t walk_req,
    output logic [63:0] mem_ff
);
    always_ff @(posedge clk) begin
        if (ld) mem_ff <= ld_data;
        else if (acc_upd) mem_ff <= acc_entry;
    end
    assign walk_valid = fetch;
    // Idle bus shows inverted data so a stale copy is never trusted
    assign walk_req = fetch ? {mem_ff, flags} : {~mem_ff, ~flags};
endmodule // s2l4_table_model

//--- bench/s2l4_entry_decode_checker.sv
// Assertions on the decoder ports; bound in by the testbench.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns
module s2l4_entry_decode_checker #(parameter int HOST_ADDRESS_WIDTH = 48) (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic WALK_VALID,
    input wire s2l4_pkg::walk_req_t WALK_REQ,
    input wire logic RES_VALID,
    input wire s2l4_pkg::result_t RES,
    input wire logic ACC_UPD,
    input wire logic [63:0] ACC_ENTRY,
    input wire logic [4:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [31:0] REG_RDATA
);
    localparam logic [63:0] MASK = ((64'h1 << HOST_ADDRESS_WIDTH) - 64'h1) & ~64'hFFF;
    logic [2:0] ctrl_ff;
    logic [63:0] e;
    logic clean;
    logic z;
    assign e = WALK_REQ.entry;
    assign z = WALK_REQ.zero_len;
    assign clean = !e[11] && !e[7] && !(|(e[51:0] >> HOST_ADDRESS_WIDTH));
    always_ff @(posedge CLK_SYS) begin
        if (RST) ctrl_ff <= 3'h0;
        else if (REG_WR && REG_ADDR == s2l4_pkg::OFS_CTRL)
            ctrl_ff <= REG_WDATA[2:0];
    end
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    sequence s_take(c);
        WALK_VALID && c;
    endsequence
    AST_BASE: assert property (s_take(1'b1) |=>
        RES_VALID && RES.next_base == ($past(e) & MASK)) else $error("base");
    AST_RSVD: assert property (s_take(!clean) |=>
        RES.rsvd_fault && !RES.granted) else $error("rsvd");
    AST_IOW_RSVD: assert property (s_take(!ctrl_ff[0] && e[62]) |=>
        RES.rsvd_fault) else $error("bit62 rsvd");
    AST_IO_WR: assert property (s_take(ctrl_ff[0] && !e[62]) |=>
        !RES.write_ok) else $error("io write");
    AST_IO_RD: assert property (s_take(ctrl_ff[0] && !e[61] &&
        !(ctrl_ff[1] && z && e[62])) |=> !RES.read_ok) else $error("io read");
    AST_ZLR_IO: assert property (s_take(clean && ctrl_ff[1:0] == 2'h3 &&
        e[62] && z) |=> RES.read_ok) else $error("io zero length");
    AST_LEG_WR: assert property (s_take(!ctrl_ff[0] && !e[1]) |=>
        !RES.write_ok) else $error("write");
    AST_LEG_RD: assert property (s_take(!ctrl_ff[0] && !e[0] &&
        !(ctrl_ff[1] && z && e[1])) |=> !RES.read_ok) else $error("read");
    AST_ACC: assert property (s_take(ctrl_ff[2] && !e[8]) |=>
        ACC_UPD == RES.granted) else $error("accessed update");
    AST_NO_ACC: assert property (s_take(!ctrl_ff[2] || e[8]) |=>
        !ACC_UPD) else $error("spurious update");
endmodule // s2l4_entry_decode_checker

//--- bench/s2l4_entry_decode_tb_top.sv
// Testbench: register and walk scenarios for the entry decoder.
// Assumes the table model feeds the walk port.
`timescale 1ns/1ns
module s2l4_entry_decode_tb_top;
    localparam int HOST_ADDRESS_WIDTH = 40;
    localparam logic [63:0] MASK = ((64'h1 << HOST_ADDRESS_WIDTH) - 64'h1) & ~64'hFFF;
    logic clk = 0, rst = 1, wr = 0, rd = 0, ld = 0, fetch = 0;
    logic [4:0] addr = 0;
    logic [31:0] wdata = 0, rdata;
    logic [63:0] ld_data = 0, acc_entry, mem_ff;
    logic [2:0] flags = 0;
    logic walk_valid, res_valid, acc_upd;
    s2l4_pkg::walk_req_t walk_req;
    s2l4_pkg::result_t res;
    int errors = 0, n_tests = 0, n_deny = 0;
    logic [63:0] ents [7] = '{64'h0000_00AB_CDEF_1003,
        64'h6000_0012_3456_7000, 64'h2000_0000_0000_5102,
        64'h4000_0000_0000_0001, 64'h0000_2000_0000_0003,
        64'h9FF0_0000_0000_067E, 64'h0000_0000_0000_0881};
    logic [2:0] fl [4] = '{3'h4, 3'h2, 3'h5, 3'h6};
    initial forever #20 clk = ~clk;
    s2l4_table_model i_tab (.clk(clk), .ld(ld), .ld_data(ld_data),
        .fetch(fetch), .flags(flags), .acc_upd(acc_upd),
        .acc_entry(acc_entry), .walk_valid(walk_valid),
        .walk_req(walk_req), .mem_ff(mem_ff));
    s2l4_entry_decode #(.HOST_ADDRESS_WIDTH(HOST_ADDRESS_WIDTH)) i_dut (.CLK_SYS(clk), .RST(rst),
        .WALK_VALID(walk_valid), .WALK_REQ(walk_req),
        .RES_VALID(res_valid), .RES(res), .ACC_UPD(acc_upd),
        .ACC_ENTRY(acc_entry), .REG_ADDR(addr), .REG_WDATA(wdata),
        .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata));
    task automatic chk(logic [63:0] got, logic [63:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("errors %0d n_tests %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic reg_wr(logic [4:0] a, logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic reg_rd(logic [4:0] a, logic [31:0] exp);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask
    function automatic logic [3:0] expect_res(logic [2:0] c,
        logic [63:0] e, logic [2:0] f);
        logic flt, w, r;
        flt = e[11] | e[7] | (|(e[51:0] >> HOST_ADDRESS_WIDTH));
        flt = flt | (!c[0] & e[62]);
        w = c[0] ? e[62] : e[1];
        r = (c[0] ? e[61] : e[0]) | (c[1] & f[0] & w);
        return {flt, r & !flt, w & !flt, !flt & (!f[2] | r) & (!f[1] | w)};
    endfunction
    task automatic walk(logic [2:0] c, logic [63:0] e, logic [2:0] f);
        logic [3:0] x;
        logic a;
        logic [63:0] b;
        x = expect_res(c, e, f);
        a = x[0] & c[2] & !e[8];
        b = e & MASK;
        if (!x[0]) n_deny++;
        ld <= 1'b1;
        ld_data <= e;
        @(posedge clk);
        ld <= 1'b0;
        fetch <= 1'b1;
        flags <= f;
        @(posedge clk);
        fetch <= 1'b0;
        #1 chk(res_valid, 64'h1);
        chk(res, {e & MASK, x});
        chk(acc_upd, a);
        @(posedge clk);
        #1 chk(mem_ff, e | {55'h0, a, 8'h0});
        reg_rd(s2l4_pkg::OFS_STATUS, {x[0], x[3], x[1], x[2], 1'b1});
        reg_rd(s2l4_pkg::OFS_BASE_LO, b[31:0]);
        reg_rd(s2l4_pkg::OFS_BASE_HI, b[63:32]);
        reg_rd(s2l4_pkg::OFS_ENTRY_LO, e[31:0]);
        reg_rd(s2l4_pkg::OFS_ENTRY_HI, e[63:32]);
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        reg_rd(s2l4_pkg::OFS_CTRL, 32'h0);
        reg_rd(5'h02, 32'h0);
        for (int c = 0; c < 8; c++) begin
            reg_wr(s2l4_pkg::OFS_CTRL, 32'(c));
            reg_rd(s2l4_pkg::OFS_CTRL, 32'(c));
            foreach (ents[i])
                foreach (fl[f])
                    walk(3'(c), ents[i], fl[f]);
        end
        // Every walk decodes once; denials counted alongside
        reg_rd(s2l4_pkg::OFS_CNT_DECODE, 32'h0000_00E0);
        reg_rd(s2l4_pkg::OFS_CNT_DENY, 32'(n_deny));
        reg_wr(s2l4_pkg::OFS_CNT_DECODE, 32'h0);
        reg_rd(s2l4_pkg::OFS_CNT_DECODE, 32'h0);
        reg_rd(s2l4_pkg::OFS_CNT_DENY, 32'(n_deny));
        // Mid-run reset must clear control and status
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        reg_rd(s2l4_pkg::OFS_CTRL, 32'h0);
        reg_rd(s2l4_pkg::OFS_STATUS, 32'h0);
        reg_rd(s2l4_pkg::OFS_CNT_DENY, 32'h0);
        report_and_stop;
    end
    initial begin
        #400000;
        errors++;
        report_and_stop;
    end
endmodule // s2l4_entry_decode_tb_top
bind s2l4_entry_decode s2l4_entry_decode_checker #(.HOST_ADDRESS_WIDTH(HOST_ADDRESS_WIDTH)) u_chk (
    .CLK_SYS(CLK_SYS), .RST(RST), .WALK_VALID(WALK_VALID),
    .WALK_REQ(WALK_REQ), .RES_VALID(RES_VALID), .RES(RES),
    .ACC_UPD(ACC_UPD), .ACC_ENTRY(ACC_ENTRY), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA));
